//--- rtl/svm_pkg.sv
// package: register map, field positions, timing constants for the supply voltage monitor
package svm_pkg;
    // register byte offsets on the apb bus
    localparam logic [11:0] SVM_CTRL_OFS      = 12'h000; // control byte (printed 00FF12)
    localparam logic [11:0] SVM_CFG_OFS       = 12'h004; // sleep / option register
    // field positions in the control word
    localparam int          SVM_PERIODIC_BIT  = 5;
    localparam int          SVM_CONT_BIT      = 4;
    localparam int          SVM_RESULT_LSB    = 0;
    // field positions in the config word
    localparam int          SVM_SLEEP_BIT     = 0;
    localparam int          SVM_LVR_EN_BIT    = 1;
    localparam int          SVM_OSC_STOP_BIT  = 2;
    localparam int          SVM_LVR_ACT_BIT   = 3;
    // reset values
    localparam logic        SVM_CONT_RST      = 1'b0;
    localparam logic        SVM_PERIODIC_RST  = 1'b0;
    localparam logic [3:0]  SVM_RESULT_RST    = 4'h0;
    localparam logic        SVM_LVR_EN_RST    = 1'b0;
    // timing: low-speed clock and its divisions
    localparam int          SVM_PCLK_HZ       = 250_000_000;
    localparam int          SVM_LOW_OSC_HZ    = 32_768;
    localparam int          SVM_TICK_HZ       = 2_048;
    localparam int          SVM_PERIOD_S      = 4;
    localparam int          SVM_TICKS_PER_SAMPLE = 16;
    // one sample is 16 ticks of 2048 Hz, i.e. 7.8 ms
    localparam int          SVM_LOW_PER_TICK  = SVM_LOW_OSC_HZ / SVM_TICK_HZ;
    localparam int          SVM_TICKS_PER_PERIOD = SVM_TICK_HZ * SVM_PERIOD_S;
    localparam int          SVM_LVR_SAMPLES   = 4;
    localparam logic [3:0]  SVM_LVR_TRIP_LVL  = 4'h0;
    localparam logic [3:0]  SVM_LVR_REL_LVL   = 4'h2;
    // fsm states, one-hot
    typedef enum logic [3:0] {
        SVM_IDLE   = 4'b0001,
        SVM_WAIT   = 4'b0010,
        SVM_SAMPLE = 4'b0100,
        SVM_DONE   = 4'b1000
    } svm_state_t;
endpackage

//--- rtl/svm_sar.sv
// 4-bit successive-approximation step logic around the external comparator
module svm_sar
    import svm_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       step,
    input  wire logic       cmp_above,
    output logic [3:0]      trial_code,
    output logic [3:0]      code
);
    logic [3:0] bit_mask;
    // one decision per step, msb first; remaining steps of the sample are idle settling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code     <= 4'h0;
            bit_mask <= 4'h0;
        end else if (start) begin
            code     <= 4'h0;
            bit_mask <= 4'h8;
        end else if (step && bit_mask != 4'h0) begin
            if (cmp_above) begin
                code <= code | bit_mask;
            end
            bit_mask <= bit_mask >> 1;
        end
    end
    assign trial_code = code | bit_mask;
endmodule

//--- rtl/svm_tick_div.sv
// low-speed clock edge detector and 2048 hz tick divider
module svm_tick_div
    import svm_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic low_osc_clk,
    output logic      tick
);
    logic       osc_q;
    logic [3:0] div;
    // low oscillator taken as synchronous input; rising edge counts as one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= low_osc_clk;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div  <= 4'h0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (low_osc_clk && !osc_q) begin
                if (div == 4'(SVM_LOW_PER_TICK - 1)) begin
                    div  <= 4'h0;
                    tick <= 1'b1;
                end else begin
                    div <= div + 4'h1;
                end
            end
        end
    end
endmodule

//--- rtl/svm_top.sv
// supply voltage monitor: apb registers, sampling sequencer, sleep hold, low-voltage reset
//
// Implementation choices: register access over APB and the register offsets.
module svm_top
    import svm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        low_osc_clk,
    input  wire logic        cmp_above,
    input  wire logic        sleep_instruction,
    output logic [3:0]       trial_code,
    output logic             low_freq_osc_stop,
    output logic             lvr_reset
);
    logic        tick;
    logic        continuous_sample_ctrl;
    logic        periodic_sample_ctrl;
    logic [3:0]  supply_level_result;
    logic        lvr_en;
    logic        sleep_pend;
    logic        first_pend;
    logic        saved_cont;
    logic        saved_per;
    logic [2:0]  zero_cnt;
    logic [4:0]  samp_cnt;
    logic [13:0] per_cnt;
    logic        sar_start;
    logic [3:0]  sar_code;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        busy;
    logic        samp_end;
    logic        want_start;
    svm_state_t  state;

    svm_tick_div u_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .low_osc_clk (low_osc_clk),
        .tick        (tick)
    );

    svm_sar u_sar (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (sar_start),
        .step       (tick),
        .cmp_above  (cmp_above),
        .trial_code (trial_code),
        .code       (sar_code)
    );

    // apb: zero-wait slave, unmapped reads zero and flag pslverr
    assign pready  = 1'b1;
    assign wr_ctrl = psel && penable && pwrite && paddr == SVM_CTRL_OFS;
    assign wr_cfg  = psel && penable && pwrite && paddr == SVM_CFG_OFS;
    always_comb begin
        if (paddr == SVM_CTRL_OFS) begin
            pslverr = 1'b0;
        end else if (paddr == SVM_CFG_OFS) begin
            pslverr = 1'b0;
        end else begin
            pslverr = psel && penable;
        end
    end

    // done counts as busy when the next sample follows, so continuous mode reads ready only before its first sample starts
    assign busy     = (state == SVM_SAMPLE) ||
                      (state == SVM_DONE && continuous_sample_ctrl && !sleep_pend);
    assign samp_end = busy && tick && samp_cnt == 5'(SVM_TICKS_PER_SAMPLE - 1);
    // periodic start when the 4 s interval rolls over
    assign want_start = first_pend || continuous_sample_ctrl ||
                        (periodic_sample_ctrl && per_cnt == 14'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == SVM_CTRL_OFS) begin
                // busy, not the written bit, is what software sees
                prdata <= {26'h0, periodic_sample_ctrl, busy, supply_level_result};
            end else if (paddr == SVM_CFG_OFS) begin
                prdata <= {28'h0, lvr_reset, low_freq_osc_stop, lvr_en, sleep_pend};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // control bits; hardware clears win over software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            continuous_sample_ctrl <= SVM_CONT_RST;
            periodic_sample_ctrl   <= SVM_PERIODIC_RST;
        end else if (sleep_instruction || sleep_pend) begin
            continuous_sample_ctrl <= 1'b0;
            periodic_sample_ctrl   <= 1'b0;
        end else if (samp_end && zero_cnt == 3'(SVM_LVR_SAMPLES - 1) && lvr_en &&
                     sar_code == SVM_LVR_TRIP_LVL) begin
            continuous_sample_ctrl <= 1'b1;
        end else if (lvr_reset && samp_end && sar_code >= SVM_LVR_REL_LVL) begin
            continuous_sample_ctrl <= saved_cont;
            periodic_sample_ctrl   <= saved_per;
        end else if (wr_ctrl) begin
            continuous_sample_ctrl <= pwdata[SVM_CONT_BIT];
            periodic_sample_ctrl   <= pwdata[SVM_PERIODIC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_en <= SVM_LVR_EN_RST;
        end else if (wr_cfg) begin
            lvr_en <= pwdata[SVM_LVR_EN_BIT];
        end
    end

    // sleep entry: oscillator stop waits for the running sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_pend        <= 1'b0;
            low_freq_osc_stop <= 1'b0;
        end else if (sleep_instruction && !sleep_pend && !low_freq_osc_stop) begin
            sleep_pend <= 1'b1;
        end else if (sleep_pend && (!busy || samp_end)) begin
            sleep_pend        <= 1'b0;
            low_freq_osc_stop <= 1'b1;
        end else if (wr_cfg && !pwdata[SVM_OSC_STOP_BIT]) begin
            low_freq_osc_stop <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SVM_WAIT;
        end else begin
            case (state)
                SVM_IDLE: begin
                    if (want_start && !sleep_pend && !low_freq_osc_stop) begin
                        state <= SVM_WAIT;
                    end
                end
                SVM_WAIT: begin
                    if (tick) begin
                        state <= SVM_SAMPLE;
                    end
                end
                SVM_SAMPLE: begin
                    if (samp_end) begin
                        state <= SVM_DONE;
                    end
                end
                SVM_DONE: begin
                    // back-to-back in continuous: next sample starts in the cycle after done, without waiting for a tick
                    if (continuous_sample_ctrl && !sleep_pend) begin
                        state <= SVM_SAMPLE;
                    end else begin
                        state <= SVM_IDLE;
                    end
                end
                default: state <= SVM_IDLE;
            endcase
        end
    end
    assign sar_start = (state == SVM_WAIT && tick) || (state == SVM_DONE && continuous_sample_ctrl);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt <= 5'h0;
        end else if (sar_start) begin
            samp_cnt <= 5'h0;
        end else if (busy && tick) begin
            samp_cnt <= samp_cnt + 5'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt <= 14'h0;
        end else if (!periodic_sample_ctrl) begin
            per_cnt <= 14'h0;
        end else if (tick) begin
            if (per_cnt == 14'(SVM_TICKS_PER_PERIOD - 1)) begin
                per_cnt <= 14'h0;
            end else begin
                per_cnt <= per_cnt + 14'h1;
            end
        end
    end

    // result only changes at sample end; mid-sample reads see the old level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_level_result <= SVM_RESULT_RST;
            first_pend          <= 1'b1;
        end else if (samp_end) begin
            supply_level_result <= sar_code;
            first_pend          <= 1'b0;
        end
    end

    // low-voltage reset tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_cnt   <= 3'h0;
            lvr_reset  <= 1'b0;
            saved_cont <= 1'b0;
            saved_per  <= 1'b0;
        end else if (samp_end) begin
            if (sar_code == SVM_LVR_TRIP_LVL) begin
                if (zero_cnt != 3'(SVM_LVR_SAMPLES)) begin
                    zero_cnt <= zero_cnt + 3'h1;
                end
                if (lvr_en && !lvr_reset && zero_cnt == 3'(SVM_LVR_SAMPLES - 1)) begin
                    lvr_reset  <= 1'b1;
                    saved_cont <= continuous_sample_ctrl;
                    saved_per  <= periodic_sample_ctrl;
                end
            end else begin
                zero_cnt <= 3'h0;
                if (sar_code >= SVM_LVR_REL_LVL) begin
                    lvr_reset <= 1'b0;
                end
            end
        end
    end

    result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !samp_end |=> $stable(supply_level_result))
        else $error("result changed outside sample end");
    result_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        samp_end |=> supply_level_result == $past(sar_code))
        else $error("result not taken from the search");
    busy_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy) |-> $past(tick))
        else $error("sample did not start on tick");
    osc_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(low_freq_osc_stop) |-> !busy || $past(samp_end))
        else $error("oscillator stopped mid sample");
    sleep_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_pend |=> !continuous_sample_ctrl && !periodic_sample_ctrl)
        else $error("control bits not cleared in sleep wait");
    sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_instruction |=> !continuous_sample_ctrl && !periodic_sample_ctrl)
        else $error("control bits not cleared on sleep entry");
    lvr_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(lvr_reset) |-> supply_level_result >= SVM_LVR_REL_LVL)
        else $error("reset released below level 2");
    lvr_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        lvr_reset && samp_end && sar_code < SVM_LVR_REL_LVL |=> lvr_reset)
        else $error("reset dropped on a low sample");
    mode_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(lvr_reset) && !$past(sleep_pend) && !$past(sleep_instruction) |->
        continuous_sample_ctrl == saved_cont && periodic_sample_ctrl == saved_per)
        else $error("sampling mode not restored after reset");
    cont_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lvr_reset) |-> continuous_sample_ctrl)
        else $error("low-voltage reset without continuous mode");
    cont_b2b_a: assert property (@(posedge pclk) disable iff (!presetn)
        samp_end && continuous_sample_ctrl && !sleep_pend |=> ##1 busy)
        else $error("continuous sampling left a gap");
    periodic_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == SVM_IDLE && !continuous_sample_ctrl && !periodic_sample_ctrl && !first_pend
        |=> state == SVM_IDLE)
        else $error("sampling started while off");
    first_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        first_pend && !sleep_pend |-> state != SVM_IDLE)
        else $error("first sample not running");
    cover_sample_c: cover property (@(posedge pclk) disable iff (!presetn) samp_end);
    cover_lvr_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(lvr_reset));
    cover_sleep_c: cover property (@(posedge pclk) disable iff (!presetn)
        sleep_pend && busy);
    cover_b2b_c: cover property (@(posedge pclk) disable iff (!presetn)
        state == SVM_DONE && busy);
    cover_periodic_c: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(busy) && periodic_sample_ctrl && !continuous_sample_ctrl);
endmodule

//--- test/supply_voltage_monitor_bench.sv
// self-checking bench for the supply voltage monitor
module supply_voltage_monitor_bench
    import svm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        low_osc_clk = 1'b0;
    logic        sleep_instruction = 1'b0;
    logic        low_freq_osc_stop;
    logic        lvr_reset;
    logic [3:0]  trial_code;
    logic [3:0]  lvl = 4'h9;
    logic        cmp_above;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;

    // supply sits half a step above lvl, so the search settles on lvl exactly
    assign cmp_above = (trial_code <= lvl);

    svm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_osc_clk(low_osc_clk), .cmp_above(cmp_above),
        .sleep_instruction(sleep_instruction), .trial_code(trial_code),
        .low_freq_osc_stop(low_freq_osc_stop), .lvr_reset(lvr_reset));

    initial begin
        forever #2 pclk = ~pclk;
    end
    // low clock much faster than real so a sample is 1024 pclk cycles
    initial begin
        forever begin
            repeat (2) @(posedge pclk);
            low_osc_clk <= ~low_osc_clk;
        end
    end
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; idle cycle after so strobes never toggle twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic wait_busy(input logic b);
        logic [31:0] r;
        int          n;
        n = 0;
        rd(SVM_CTRL_OFS, r);
        while (r[SVM_CONT_BIT] !== b && n < 1500) begin
            rd(SVM_CTRL_OFS, r);
            n++;
        end
        chk("busy", b, r[SVM_CONT_BIT]);
    endtask

    // strict: only the old or the new level may be seen meanwhile
    task automatic poll_lvl(input logic [3:0] nw, input logic [3:0] od, input bit strict);
        logic [31:0] r;
        int          n;
        n = 0;
        rd(SVM_CTRL_OFS, r);
        while (r[3:0] !== nw && n < 800) begin
            if (strict && r[3:0] !== od) chk("held result", od, r[3:0]);
            rd(SVM_CTRL_OFS, r);
            n++;
        end
        chk("new result", nw, r[3:0]);
    endtask

    task automatic t_reset();
        logic [31:0] r;
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(SVM_CTRL_OFS, r);
        chk("first result", 32'h9, r[3:0]);
        chk("ctrl bits", 32'h0, r[5:4]);
        rd(SVM_CFG_OFS, r);
        chk("cfg reset", 32'h0, r[3:0]);
        $display("test reset done");
    endtask

    task automatic t_cont();
        logic [31:0] r;
        int          t;
        int          d;
        lvl <= 4'h6;
        wr(SVM_CTRL_OFS, 32'h10);
        poll_lvl(4'h6, 4'h9, 1'b0);
        lvl <= 4'h7;
        poll_lvl(4'h7, 4'h6, 1'b1);
        t = cyc;
        lvl <= 4'h6;
        poll_lvl(4'h6, 4'h7, 1'b1);
        d = cyc - t;
        chk("sample spacing", 32'h1, (d >= 1018 && d <= 1030));
        wr(SVM_CTRL_OFS, 32'h0);
        rd(SVM_CTRL_OFS, r);
        chk("busy after cancel", 32'h1, r[SVM_CONT_BIT]);
        wait_busy(1'b0);
        lvl <= 4'h3;
        repeat (1200) @(posedge pclk);
        rd(SVM_CTRL_OFS, r);
        chk("off keeps result", 32'h06, r[5:0]);
        $display("test continuous done");
    endtask

    task automatic t_levels();
        wr(SVM_CTRL_OFS, 32'h10);
        for (int i = 0; i < 16; i++) begin
            lvl <= i[3:0];
            poll_lvl(i[3:0], 4'h0, 1'b0);
        end
        wr(SVM_CTRL_OFS, 32'h0);
        wait_busy(1'b0);
        $display("test levels done");
    endtask

    task automatic t_map();
        logic [31:0] r;
        logic        e;
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk("unmapped err", 32'h1, e);
        chk("unmapped data", 32'h0, r);
        wr(SVM_CTRL_OFS, 32'h05);
        rd(SVM_CTRL_OFS, r);
        chk("result read only", 32'h0F, r[5:0]);
        lvl <= 4'hC;
        wr(SVM_CTRL_OFS, 32'h20);
        rd(SVM_CTRL_OFS, r);
        chk("periodic bit", 32'h1, r[SVM_PERIODIC_BIT]);
        wait_busy(1'b1);
        wr(SVM_CTRL_OFS, 32'h0);
        rd(SVM_CTRL_OFS, r);
        chk("periodic off", 32'h0, r[SVM_PERIODIC_BIT]);
        chk("busy through cancel", 32'h1, r[SVM_CONT_BIT]);
        wait_busy(1'b0);
        rd(SVM_CTRL_OFS, r);
        chk("periodic result", 32'h0C, r[5:0]);
        $display("test map done");
    endtask

    task automatic t_lvr();
        logic [31:0] r;
        int          t;
        int          n;
        wr(SVM_CFG_OFS, 32'h2);
        lvl <= 4'h0;
        wr(SVM_CTRL_OFS, 32'h10);
        t = cyc;
        n = 0;
        while (lvr_reset !== 1'b1 && n < 6000) begin
            @(posedge pclk);
            n++;
        end
        chk("trip delay", 32'h1, (cyc - t >= 4090 && cyc - t <= 4250));
        rd(SVM_CFG_OFS, r);
        chk("trip flag", 32'h1, r[SVM_LVR_ACT_BIT]);
        lvl <= 4'h1;
        repeat (2200) @(posedge pclk);
        chk("level one holds", 32'h1, lvr_reset);
        lvl <= 4'h2;
        n = 0;
        while (lvr_reset !== 1'b0 && n < 2500) begin
            @(posedge pclk);
            n++;
        end
        chk("release", 32'h0, lvr_reset);
        repeat (1100) @(posedge pclk);
        rd(SVM_CTRL_OFS, r);
        chk("mode restored", 32'h12, r[4:0]);
        wr(SVM_CFG_OFS, 32'h0);
        wr(SVM_CTRL_OFS, 32'h0);
        wait_busy(1'b0);
        $display("test low voltage done");
    endtask

    task automatic t_sleep();
        logic [31:0] r;
        logic        osc_seen;
        int          n;
        wr(SVM_CTRL_OFS, 32'h30);
        wait_busy(1'b1);
        sleep_instruction <= 1'b1;
        @(posedge pclk);
        sleep_instruction <= 1'b0;
        // stop flag taken before the read whose busy bit it is paired with
        osc_seen = low_freq_osc_stop;
        rd(SVM_CTRL_OFS, r);
        chk("sleep clears periodic", 32'h0, r[SVM_PERIODIC_BIT]);
        n = 0;
        while (r[SVM_CONT_BIT] === 1'b1 && n < 800) begin
            chk("osc held", 32'h0, osc_seen);
            osc_seen = low_freq_osc_stop;
            rd(SVM_CTRL_OFS, r);
            n++;
        end
        chk("sample ends", 32'h0, r[SVM_CONT_BIT]);
        chk("osc stop", 32'h1, low_freq_osc_stop);
        repeat (1200) @(posedge pclk);
        rd(SVM_CTRL_OFS, r);
        chk("stays off", 32'h0, r[5:4]);
        $display("test sleep done");
    endtask

    // full run is about 37k cycles
    initial begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_cont();
        t_levels();
        t_map();
        t_lvr();
        t_sleep();
        conclude();
    end
endmodule
